//--- scsp_host.sv
// Host side of the supply control serial port link, acting as the serial bus master.
// Assumes the bench calls xfer by hierarchical name and nothing else drives these pins.
`timescale 1ns/10ps
`default_nettype none
module scsp_host (
  output logic      select,
  output logic      sclk,
  output logic      serial_in,
  input  wire logic serial_out_line
);
  // ==========================================================================
  // Link timing: 200 ns serial clock period
  localparam time HALF_T = 100;
  localparam time LEAD_T = 150;

  // Serial clock idles low between frames
  initial begin
    select    = 1'b0;
    sclk      = 1'b0;
    serial_in = 1'b1;
  end

  // ==========================================================================
  // One frame of nbits; status bit k is taken just before clock rise k+1
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    select = 1'b1;
    #(LEAD_T);
    for (int k = 0; k < nbits; k++) begin
      serial_in = word[k];
      #(HALF_T / 2);
      rx[k] = serial_out_line;
      sclk = 1'b1;
      #(HALF_T);
      sclk = 1'b0;
      #(HALF_T / 2);
    end
    #(HALF_T);
    select = 1'b0;
    // Released data line shows the inverse so a stale bit is never mistaken for data
    serial_in = ~serial_in;
    #(2 * HALF_T);
  endtask
endmodule
`default_nettype wire

//--- scsp_pkg.sv
// Constants shared by the supply control serial port.
// Assumes a single 40 MHz core clock; all pins are sampled through synchronisers.
package scsp_pkg;

  // ==========================================================================
  // Serial word
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned BITCNT_W    = 5;
  localparam logic [4:0]  BITCNT_FULL = 5'h10;

  // ==========================================================================
  // Command word fields (bit positions)
  localparam int unsigned CMD_SENSOR1     = 0;
  localparam int unsigned CMD_SENSOR2     = 1;
  localparam int unsigned CMD_SENSOR3     = 2;
  localparam int unsigned CMD_SW_BATT     = 3;
  localparam int unsigned CMD_PROG_EN     = 4;
  localparam int unsigned CMD_PROG_5V     = 5;
  localparam int unsigned CMD_BUS_RX_EN   = 6;
  localparam int unsigned CMD_BUS_WAKE    = 7;
  localparam int unsigned CMD_USED_BITS   = 8;
  localparam logic [7:0]  CMD_RESET       = 8'hff;

  // ==========================================================================
  // Status word fields
  localparam int unsigned STAT_CURR_LSB   = 0;
  localparam int unsigned STAT_THERM_LSB  = 4;
  localparam int unsigned N_OUTPUTS       = 4;
  localparam logic [3:0]  THERM_RESET     = 4'h0;
  localparam logic [7:0]  STAT_UPPER      = 8'h00;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  localparam int unsigned SEQ_TIME_US     = 800;
  localparam int unsigned SEQ_CYCLES      =
    (SEQ_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SEQ_CNT_W       = 16;

  // ==========================================================================
  // Power state, Gray coded along on -> down -> sleep -> up -> on
  typedef enum logic [1:0] {
    PWR_ON    = 2'h0,
    PWR_DOWN  = 2'h1,
    PWR_SLEEP = 2'h3,
    PWR_UP    = 2'h2
  } scsp_pwr_type;

endpackage

//--- scsp_sync.sv
// Two-flop synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/10ps
`default_nettype none
module scsp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ==========================================================================
  // Stages
  // First stage feeds only the second one
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- scsp_top.sv
// Serial control and status port of a multi-output supply device.
// Assumes the serial clock is at most 5 MHz so the 40 MHz clock sees every edge.
//
// Contract
// RL1: Select is active high; transfers happen only while select is high.
// RL2: Serial data is sampled on each serial clock rise while selected.
// RL3: A transfer is 16 bits; the shift register is full after 16.
// RL4: Command and status words move LSB first, first in first out.
// RL5: Received command bits take effect only on the falling edge of select.
// RL6: Select rise loads status into the shifter and shows status bit 0.
// RL7: Each later serial clock rise shows the next status bit.
// RL8: Deselected, clock and data are ignored and the output is released.
// RL9: Host changes select only while the serial clock is low.
// RL10: Host waits about 125 ns from select rise to first clock rise; scsp_host waits 200 ns.
// RL11: Host runs the serial clock no faster than 5.0 MHz.
// RL12: Host keeps serial data steady across the serial clock rise.
// RL13: Bits 0-4 switch sensor 1-3, battery and programming supplies; default on.
// RL14: Bit 5 picks programming level, 1 is 5V, 0 is 3.3V; default 1.
// RL15: Bit 6 enables the bus receiver, which stays powered while supplies are off.
// RL16: Bit 7 arms bus wake-up when 1, disables it when 0; default 1.
// RL17: Armed wake on bus activity in low power runs power-up, raises wake output.
// RL18: Sleep request falling edge returns the device to low quiescent mode.
// RL19: Status bits 4-7 latch thermal limits since last transfer, per output.
// RL20: Latched thermal bits clear on the trailing edge of select.
// RL21: Status bits 0-3 show live current limit per output, unlatched.
// RL22: Sleep request fall powers down even when held on, without resets.
// RL23: With a wrong bit count, apply the shifter as it stands at select fall.
// RL24: Status bits 15-8 read zero; command bits 15-8 have no effect.
`timescale 1ns/10ps
`default_nettype none
module scsp_top #(
  parameter int unsigned SEQ_CYCLES = scsp_pkg::SEQ_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       select,
  input  wire logic       sclk,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_oe,
  input  wire logic [3:0] thermal_limit,
  input  wire logic [3:0] current_limit,
  input  wire logic       bus_activity,
  input  wire logic       sleep_req,
  output logic            sensor_supply_1,
  output logic            sensor_supply_2,
  output logic            sensor_supply_3,
  output logic            switched_battery_out,
  output logic            prog_supply_en,
  output logic            prog_supply_5v,
  output logic            bus_rx_en,
  output logic            bus_wake_arm,
  output logic            wake_indication_out,
  output logic            regulators_on,
  output logic            power_seq_busy
);

  // ==========================================================================
  // Input synchronisation
  logic [12:0] pins_s;
  logic        cs_s;
  logic        sclk_s;
  logic        din_s;
  logic        bus_act_s;
  logic        sleep_s;
  logic [3:0]  therm_s;
  logic [3:0]  curr_s;

  scsp_sync #(
    .WIDTH    (13)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .async_in ({select, sclk, serial_in, bus_activity, sleep_req,
                thermal_limit, current_limit}),
    .sync_out (pins_s)
  );

  assign {cs_s, sclk_s, din_s, bus_act_s, sleep_s, therm_s, curr_s} = pins_s;

  // ==========================================================================
  // Edge detection on synchronised levels
  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  logic cs_d_q;
  logic sclk_d_q;
  logic sleep_d_q;
  logic cs_rise;
  logic cs_fall;
  logic sclk_rise;
  logic sleep_fall;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_d_q    <= 1'b0;
      sclk_d_q  <= 1'b0;
      sleep_d_q <= 1'b0;
    end else begin
      cs_d_q    <= cs_s;
      sclk_d_q  <= sclk_s;
      sleep_d_q <= sleep_s;
    end
  end

  assign cs_rise    = rose(cs_s, cs_d_q);
  assign cs_fall    = rose(cs_d_q, cs_s);
  // Clock edges count only inside a selected frame
  assign sclk_rise  = rose(sclk_s, sclk_d_q) & cs_s & cs_d_q;  // [RL1] [RL8]
  assign sleep_fall = rose(sleep_d_q, sleep_s);

  // ==========================================================================
  // Status word
  logic [3:0]  therm_q;
  logic [15:0] status_word;

  // Current flags are live, thermal flags latched, upper byte zero
  assign status_word = {scsp_pkg::STAT_UPPER, therm_q, curr_s};  // [RL21] [RL24]

  // Set wins over the clear at select fall so a thermal event still active then is not lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      therm_q <= scsp_pkg::THERM_RESET;
    end else if (cs_fall) begin
      therm_q <= therm_s;  // [RL20]
    end else begin
      therm_q <= therm_q | therm_s;  // [RL19]
    end
  end

  // ==========================================================================
  // Shift register and bit count
  logic [15:0]                   shift_q;
  logic [scsp_pkg::BITCNT_W-1:0] bitcnt_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q <= '0;
    end else if (cs_rise) begin
      shift_q <= status_word;  // [RL6]
    end else if (sclk_rise) begin
      // Data enters at the top, status leaves at the bottom: LSB first both ways
      shift_q <= {din_s, shift_q[15:1]};  // [RL2] [RL4]
    end
  end

  // Count saturates at full; extra edges still shift but are not counted
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bitcnt_q <= '0;
    end else if (cs_rise) begin
      bitcnt_q <= '0;
    end else if (sclk_rise && bitcnt_q != scsp_pkg::BITCNT_FULL) begin
      bitcnt_q <= bitcnt_q + 5'h01;  // [RL3]
    end
  end

  // ==========================================================================
  // Serial output
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= cs_s;  // [RL8]
      if (cs_rise) begin
        serial_out <= status_word[0];  // [RL6]
      end else if (sclk_rise) begin
        serial_out <= shift_q[1];  // [RL7]
      end else if (!cs_s) begin
        serial_out <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Command register
  logic [7:0] ctrl_q;

  // Applied only at select fall, whatever the bit count was; upper byte dropped
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= scsp_pkg::CMD_RESET;  // [RL13] [RL14] [RL16]
    end else if (cs_fall) begin
      ctrl_q <= shift_q[7:0];  // [RL5] [RL23] [RL24]
    end
  end

  assign sensor_supply_1      = ctrl_q[scsp_pkg::CMD_SENSOR1];  // [RL13]
  assign sensor_supply_2      = ctrl_q[scsp_pkg::CMD_SENSOR2];
  assign sensor_supply_3      = ctrl_q[scsp_pkg::CMD_SENSOR3];
  assign switched_battery_out = ctrl_q[scsp_pkg::CMD_SW_BATT];
  assign prog_supply_en       = ctrl_q[scsp_pkg::CMD_PROG_EN];
  assign prog_supply_5v       = ctrl_q[scsp_pkg::CMD_PROG_5V];  // [RL14]
  // Receiver enable is independent of power state, so it stays on in sleep
  assign bus_rx_en            = ctrl_q[scsp_pkg::CMD_BUS_RX_EN];  // [RL15]
  assign bus_wake_arm         = ctrl_q[scsp_pkg::CMD_BUS_WAKE];  // [RL16]

  // ==========================================================================
  // Power state
  scsp_pkg::scsp_pwr_type           pwr_q;
  logic [scsp_pkg::SEQ_CNT_W-1:0]   seq_cnt_q;
  logic                             seq_done;
  localparam int unsigned                    SEQ_LAST_I = SEQ_CYCLES - 1;
  localparam logic [scsp_pkg::SEQ_CNT_W-1:0] SEQ_LAST   =
    SEQ_LAST_I[scsp_pkg::SEQ_CNT_W-1:0];

  assign seq_done = (seq_cnt_q == SEQ_LAST);

  // Reset outputs are not part of this block: a sleep power-down never asserts them
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pwr_q <= scsp_pkg::PWR_ON;
    end else begin
      case (pwr_q)
        scsp_pkg::PWR_ON: begin
          if (sleep_fall) begin
            pwr_q <= scsp_pkg::PWR_DOWN;  // [RL18] [RL22]
          end
        end
        scsp_pkg::PWR_DOWN: begin
          if (seq_done) begin
            pwr_q <= scsp_pkg::PWR_SLEEP;
          end
        end
        scsp_pkg::PWR_SLEEP: begin
          if ((bus_wake_arm && bus_act_s) || sleep_s) begin
            pwr_q <= scsp_pkg::PWR_UP;  // [RL17]
          end
        end
        default: begin
          if (seq_done) begin
            pwr_q <= scsp_pkg::PWR_ON;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seq_cnt_q <= '0;
    end else if (pwr_q == scsp_pkg::PWR_DOWN || pwr_q == scsp_pkg::PWR_UP) begin
      seq_cnt_q <= seq_done ? '0 : seq_cnt_q + 16'h0001;
    end else begin
      seq_cnt_q <= '0;
    end
  end

  // Wake indication holds until the host sends the device back to sleep
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wake_indication_out <= 1'b0;
    end else if (pwr_q == scsp_pkg::PWR_SLEEP && bus_wake_arm && bus_act_s) begin
      wake_indication_out <= 1'b1;  // [RL17]
    end else if (sleep_fall) begin
      wake_indication_out <= 1'b0;  // [RL18]
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      regulators_on  <= 1'b1;
      power_seq_busy <= 1'b0;
    end else begin
      regulators_on  <= (pwr_q != scsp_pkg::PWR_SLEEP);
      power_seq_busy <= (pwr_q == scsp_pkg::PWR_DOWN) || (pwr_q == scsp_pkg::PWR_UP);
    end
  end

  // ==========================================================================
  // Assertions
  sequence s_frame_open;
    cs_rise;
  endsequence

  sequence s_status_shown;
    serial_out_oe && serial_out == $past(status_word[0]);
  endsequence

  property p_open_shows_bit0;
    @(posedge clock) disable iff (!rstn)
      s_frame_open |=> s_status_shown;
  endproperty
  a_open_shows_bit0: assert property (p_open_shows_bit0)  // [RL6]
    else $error("select rise did not present status bit 0");

  property p_release_when_deselected;
    @(posedge clock) disable iff (!rstn)
      !cs_s |=> !serial_out_oe ##1 !serial_out_oe || cs_s;
  endproperty
  a_release_when_deselected: assert property (p_release_when_deselected)  // [RL8]
    else $error("serial output driven while deselected");

  property p_next_bit;
    @(posedge clock) disable iff (!rstn)
      sclk_rise |=> serial_out == $past(shift_q[1]) && shift_q[0] == serial_out;
  endproperty
  a_next_bit: assert property (p_next_bit)  // [RL7] [RL4]
    else $error("next status bit not shown after clock rise");

  property p_sample_in;
    @(posedge clock) disable iff (!rstn)
      sclk_rise |=> shift_q[15] == $past(din_s);
  endproperty
  a_sample_in: assert property (p_sample_in)  // [RL2]
    else $error("serial data not sampled on clock rise");

  property p_no_shift_deselected;
    @(posedge clock) disable iff (!rstn)
      !cs_s && !cs_d_q |=> $stable(shift_q);
  endproperty
  a_no_shift_deselected: assert property (p_no_shift_deselected)  // [RL1]
    else $error("shifter moved while deselected");

  property p_count_bound;
    @(posedge clock) disable iff (!rstn)
      bitcnt_q <= scsp_pkg::BITCNT_FULL;
  endproperty
  a_count_bound: assert property (p_count_bound)  // [RL3]
    else $error("bit count passed sixteen");

  property p_apply_at_fall;
    @(posedge clock) disable iff (!rstn)
      cs_fall |=> ctrl_q == $past(shift_q[7:0]);
  endproperty
  a_apply_at_fall: assert property (p_apply_at_fall)  // [RL5] [RL23]
    else $error("command not applied at select fall");

  property p_ctrl_hold;
    @(posedge clock) disable iff (!rstn)
      !cs_fall |=> $stable(ctrl_q);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)  // [RL5]
    else $error("command changed outside select fall");

  property p_thermal_latch;
    @(posedge clock) disable iff (!rstn)
      |therm_s |=> (therm_q & $past(therm_s)) == $past(therm_s);
  endproperty
  a_thermal_latch: assert property (p_thermal_latch)  // [RL19]
    else $error("thermal event not latched");

  property p_thermal_clear;
    @(posedge clock) disable iff (!rstn)
      cs_fall && therm_s == 4'h0 |=> therm_q == 4'h0;
  endproperty
  a_thermal_clear: assert property (p_thermal_clear)  // [RL20]
    else $error("thermal flags not cleared at select fall");

  property p_current_live;
    @(posedge clock) disable iff (!rstn)
      cs_rise |=> shift_q == {8'h00, $past(therm_q), $past(curr_s)};
  endproperty
  a_current_live: assert property (p_current_live)  // [RL21] [RL24]
    else $error("status word layout wrong");

  property p_wake;
    @(posedge clock) disable iff (!rstn)
      pwr_q == scsp_pkg::PWR_SLEEP && bus_wake_arm && bus_act_s
        |=> pwr_q == scsp_pkg::PWR_UP && wake_indication_out;
  endproperty
  a_wake: assert property (p_wake)  // [RL17]
    else $error("armed bus activity did not wake");

  property p_sleep_down;
    @(posedge clock) disable iff (!rstn)
      pwr_q == scsp_pkg::PWR_ON && sleep_fall |=> pwr_q == scsp_pkg::PWR_DOWN
        ##1 power_seq_busy;
  endproperty
  a_sleep_down: assert property (p_sleep_down)  // [RL18] [RL22]
    else $error("sleep request did not start power-down");

endmodule
`default_nettype wire

//--- scsp_top_tb.sv
// Self-checking bench for the supply control serial port top.
// Assumes scsp_host drives the link pins and the power sequence is shortened to 8 cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module scsp_top_tb;
  localparam int unsigned SEQ = 8;
  localparam time         DRV = 1;
  logic        clock;
  logic        rstn;
  logic [3:0]  thermal_limit;
  logic [3:0]  current_limit;
  logic        bus_activity;
  logic        sleep_req;
  logic [15:0] rx;
  int          fails;
  int          checks;
  wire logic   select;
  wire logic   sclk;
  wire logic   serial_in;
  wire logic   serial_out;
  wire logic   serial_out_oe;
  wire logic   sensor_supply_1;
  wire logic   sensor_supply_2;
  wire logic   sensor_supply_3;
  wire logic   switched_battery_out;
  wire logic   prog_supply_en;
  wire logic   prog_supply_5v;
  wire logic   bus_rx_en;
  wire logic   bus_wake_arm;
  wire logic   wake_indication_out;
  wire logic   regulators_on;
  wire logic   power_seq_busy;
  wire logic   serial_out_line = serial_out_oe ? serial_out : 1'bz;
  wire logic [7:0] ctrl = {bus_wake_arm, bus_rx_en, prog_supply_5v, prog_supply_en,
    switched_battery_out, sensor_supply_3, sensor_supply_2, sensor_supply_1};

  // ==========================================================================
  // Design and host
  scsp_top #(.SEQ_CYCLES(SEQ)) dut (
    .clock               (clock),
    .rstn                (rstn),
    .select              (select),
    .sclk                (sclk),
    .serial_in           (serial_in),
    .serial_out          (serial_out),
    .serial_out_oe       (serial_out_oe),
    .thermal_limit       (thermal_limit),
    .current_limit       (current_limit),
    .bus_activity        (bus_activity),
    .sleep_req           (sleep_req),
    .sensor_supply_1     (sensor_supply_1),
    .sensor_supply_2     (sensor_supply_2),
    .sensor_supply_3     (sensor_supply_3),
    .switched_battery_out(switched_battery_out),
    .prog_supply_en      (prog_supply_en),
    .prog_supply_5v      (prog_supply_5v),
    .bus_rx_en           (bus_rx_en),
    .bus_wake_arm        (bus_wake_arm),
    .wake_indication_out (wake_indication_out),
    .regulators_on       (regulators_on),
    .power_seq_busy      (power_seq_busy)
  );

  scsp_host host (
    .select         (select),
    .sclk           (sclk),
    .serial_in      (serial_in),
    .serial_out_line(serial_out_line)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ==========================================================================
  // Helpers
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #(DRV);
  endtask

  // Bounded wait on busy (sel 0) or regulators_on (sel 1); n is cycles spent
  task automatic wait_sig(input int sel, input logic want, output int n);
    logic v;
    v = 1'bx;
    for (n = 0; n < 40; n++) begin
      v = (sel == 0) ? power_seq_busy : regulators_on;
      if (v === want) break;
      tick(1);
    end
    if (n == 40) begin
      fails++;
      $display("wrong value power wait expected %h seen %h", want, v);
      wrap_up();
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    `CHK("ctrl after reset", 8'hff, ctrl)
    `CHK("oe after reset", 1'b0, serial_out_oe)
    `CHK("wake after reset", 1'b0, wake_indication_out)
    `CHK("regs after reset", 1'b1, regulators_on)
    $display("test reset done");
  endtask

  task automatic t_command;
    logic [15:0] words [4];
    logic [7:0]  prev;
    words = '{16'hff00, 16'h005a, 16'h00a5, 16'h00ff};
    foreach (words[i]) begin
      prev = ctrl;
      fork
        host.xfer(words[i], 16, rx);
        begin
          #3400;
          `CHK("ctrl mid frame", prev, ctrl)
          `CHK("oe mid frame", 1'b1, serial_out_oe)
        end
      join
      `CHK("ctrl", words[i][7:0], ctrl)
      `CHK("oe after frame", 1'b0, serial_out_oe)
    end
    $display("test command done");
  endtask

  task automatic t_status;
    logic [3:0] th;
    for (int i = 0; i < 4; i++) begin
      th = 4'h1 << i;
      current_limit = ~th;
      thermal_limit = th;
      tick(4);
      thermal_limit = 4'h0;
      tick(4);
      host.xfer(16'h00ff, 16, rx);
      `CHK("status", {8'h00, th, ~th}, rx)
    end
    current_limit = 4'h0;
    tick(4);
    host.xfer(16'h00ff, 16, rx);
    `CHK("status cleared", 16'h0000, rx)
    $display("test status done");
  endtask

  task automatic t_short;
    current_limit = 4'h3;
    tick(4);
    host.xfer(16'h00ff, 0, rx);
    `CHK("ctrl empty frame", 8'h03, ctrl)
    host.xfer(16'h00ff, 8, rx);
    `CHK("status short frame", 8'h03, rx[7:0])
    `CHK("ctrl short frame", 8'h00, ctrl)
    current_limit = 4'h0;
    tick(4);
    host.xfer(16'h00ff, 16, rx);
    $display("test short done");
  endtask

  task automatic t_power;
    int n;
    sleep_req = 1'b0;
    wait_sig(0, 1'b1, n);
    `CHK("down start", 1'b1, n <= 6)
    wait_sig(1, 1'b0, n);
    `CHK("down time", 1'b1, n inside {[SEQ - 1 : SEQ + 2]})
    bus_activity = 1'b1;
    wait_sig(0, 1'b1, n);
    bus_activity = 1'b0;
    wait_sig(0, 1'b0, n);
    `CHK("up time", 1'b1, n inside {[SEQ - 1 : SEQ + 2]})
    `CHK("wake on bus", 1'b1, wake_indication_out)
    `CHK("regs up", 1'b1, regulators_on)
    host.xfer(16'h007f, 16, rx);
    sleep_req = 1'b1;
    tick(4);
    sleep_req = 1'b0;
    wait_sig(1, 1'b0, n);
    `CHK("wake cleared", 1'b0, wake_indication_out)
    bus_activity = 1'b1;
    tick(40);
    `CHK("disarmed sleep", 1'b0, regulators_on)
    bus_activity = 1'b0;
    sleep_req = 1'b1;
    wait_sig(1, 1'b1, n);
    wait_sig(0, 1'b0, n);
    `CHK("wake by pin", 1'b0, wake_indication_out)
    host.xfer(16'h00ff, 16, rx);
    $display("test power done");
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    rstn = 1'b0;
    thermal_limit = 4'h0;
    current_limit = 4'h0;
    bus_activity = 1'b0;
    sleep_req = 1'b1;
    rx = 16'h0000;
    fails = 0;
    checks = 0;
    tick(2);
    rstn = 1'b1;
    tick(4);
    t_reset();
    t_command();
    t_status();
    t_short();
    t_power();
    wrap_up();
  end

  initial begin
    #2000000;
    fails++;
    $display("wrong value run time expected %h seen %h", 1'b0, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
